// *** logic/noa_defs.svh ***
// register offsets, field positions, reset values and counts of the oscillator
`ifndef NOA_DEFS_SVH
`define NOA_DEFS_SVH

`define NOA_ADR_W 8
`define NOA_OFS_CONTROL 8'h00
`define NOA_OFS_CLOCK 8'h04
`define NOA_OFS_ACC_LOW 8'h08
`define NOA_OFS_ACC_HIGH 8'h0c
`define NOA_OFS_ACC_UPPER 8'h10
`define NOA_OFS_STEP_LOW 8'h14
`define NOA_OFS_STEP_HIGH 8'h18
`define NOA_OFS_STEP_UPPER 8'h1c
`define NOA_OFS_IRQ 8'h20

`define NOA_BIT_ON 7
`define NOA_BIT_LEVEL 5
`define NOA_BIT_INVERT 4
`define NOA_BIT_PFM 0
`define NOA_POS_PW 5
`define NOA_POS_CKS 0
`define NOA_BIT_IRQ_FLAG 0
`define NOA_BIT_IRQ_IE 1
`define NOA_BIT_IRQ_PERIPHERAL_IRQ_ENABLE 2
`define NOA_BIT_IRQ_GIE 3

`define NOA_ACC_W 20
`define NOA_STEP_RESET 20'h00001
`define NOA_XFER_EDGES 2'h2

`endif

// *** logic/noa_edge_sync.sv ***
// two-flop synchronisers with rising edge detect, one per asynchronous input
`timescale 1ns/10ps
module noa_edge_sync #(
  parameter int W = 2
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_rise
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // first stage feeds only the second; edge taken between stages two and three
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= i_async[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      assign o_rise[g] = s2_reg & ~s3_reg;
    end
  endgenerate
endmodule

// *** logic/noa_osc_accum.sv ***
// phase accumulator oscillator with wishbone register slave
//
// Overview of operation
// - each input clock edge adds buffered step; carry overflows
// - disabled: step byte writes reach buffer at once
// - toggle mode inverts output on every overflow
// - control bit 0 picks toggle or pulse mode
// - pulse mode: active for selected periods, then inactive
// - pulse starts at first input edge after overflow
// - clock bits 7-5 give 2^code input periods
// - control bit 4 set makes active level low
// - polarity change with interrupts enabled sets flag
// - control bit 5 reads final output level
// - final output goes to logic cell, waveform generator
// - overflow sets flag; request needs all four enables
// - flag stays set until software clears it
// - reset zeroes all; step low bit 0 is one
// - accumulator runs from selected input clock only
// - enabled with fast oscillator selected keeps it awake
// - clock bits 1-0 select input clock source
// - control bit 7 turns module on
// - enabled: step low write loads buffer second edge
// - accumulator as three bytes, upper nibble reads zero
// - step as three bytes, upper nibble reads zero
`timescale 1ns/10ps
`include "noa_defs.svh"
module noa_osc_accum
  import noa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`NOA_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_fast_internal_osc,
  input wire logic i_logic_cell3_output,
  output logic o_osc_out,
  output logic o_irq_req,
  output logic o_keep_fast_osc
);

  noa_state_t s_reg;
  noa_state_t s_next;
  logic [1:0] rise;

  // pin-side clocks are sampled, so their rate must stay well under half of i_clk
  noa_edge_sync #(
    .W(2)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async({i_logic_cell3_output, i_fast_internal_osc}),
    .o_rise(rise)
  );

  logic req;
  logic wr;
  logic [7:0] wd;
  logic tick;
  logic carry;
  logic [19:0] sum;
  logic ovf;
  logic pol_evt;

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    req = i_wb_cyc & i_wb_stb & ~s_reg.ack;
    wr = req & i_wb_we & i_wb_sel[0];
    wd = i_wb_dat[7:0];
    pol_evt = 1'b0;

    // input clock edge as a one-cycle enable
    case (s_reg.clock_source_code)
      NOA_SRC_FAST_OSC: tick = rise[0];
      NOA_SRC_SYS_CLK: tick = 1'b1;
      NOA_SRC_LOGIC_CELL3: tick = rise[1];
      default: tick = 1'b0;
    endcase

    {carry, sum} = {1'b0, s_reg.phase_accumulator} + {1'b0, s_reg.step_buf};
    ovf = s_reg.module_on & tick & carry;

    if (s_reg.module_on && tick) begin
      s_next.phase_accumulator = sum;
      if (s_reg.pulse_mode_select) begin
        s_next.ovf_pend = ovf;
        if (s_reg.ovf_pend) begin
          s_next.raw = 1'b1;
          s_next.pulse_left = (8'h01 << s_reg.pulse_width_code) - 8'h01;
        end else if (s_reg.pulse_left != 8'h00) begin
          s_next.pulse_left = s_reg.pulse_left - 8'h01;
        end else begin
          s_next.raw = 1'b0;
        end
      end else begin
        s_next.ovf_pend = 1'b0;
        if (ovf) begin
          s_next.raw = ~s_reg.raw;
        end
      end
      // buffer follows the step on the second edge after a low byte write
      if (s_reg.xfer_cnt != 2'h0) begin
        s_next.xfer_cnt = s_reg.xfer_cnt - 2'h1;
        if (s_reg.xfer_cnt == 2'h1) begin
          s_next.step_buf = s_reg.phase_step;
        end
      end
    end
    if (!s_reg.module_on) begin
      s_next.raw = 1'b0;
      s_next.ovf_pend = 1'b0;
      s_next.pulse_left = 8'h00;
      s_next.xfer_cnt = 2'h0;
    end

    // software writes take priority over the running accumulator
    if (wr) begin
      case (i_wb_adr)
        `NOA_OFS_CONTROL: begin
          s_next.module_on = wd[`NOA_BIT_ON];
          s_next.output_invert = wd[`NOA_BIT_INVERT];
          s_next.pulse_mode_select = wd[`NOA_BIT_PFM];
          pol_evt = (wd[`NOA_BIT_INVERT] != s_reg.output_invert);
        end
        `NOA_OFS_CLOCK: begin
          s_next.pulse_width_code = wd[`NOA_POS_PW +: 3];
          s_next.clock_source_code = noa_clk_src_t'(wd[`NOA_POS_CKS +: 2]);
        end
        `NOA_OFS_ACC_LOW: s_next.phase_accumulator[7:0] = wd;
        `NOA_OFS_ACC_HIGH: s_next.phase_accumulator[15:8] = wd;
        `NOA_OFS_ACC_UPPER: s_next.phase_accumulator[19:16] = wd[3:0];
        `NOA_OFS_STEP_LOW: begin
          s_next.phase_step[7:0] = wd;
          if (s_reg.module_on) begin
            s_next.xfer_cnt = `NOA_XFER_EDGES;
          end
        end
        `NOA_OFS_STEP_HIGH: s_next.phase_step[15:8] = wd;
        `NOA_OFS_STEP_UPPER: s_next.phase_step[19:16] = wd[3:0];
        `NOA_OFS_IRQ: begin
          s_next.overflow_irq_flag = s_reg.overflow_irq_flag & wd[`NOA_BIT_IRQ_FLAG];
          s_next.overflow_irq_enable = wd[`NOA_BIT_IRQ_IE];
          s_next.peripheral_irq_enable = wd[`NOA_BIT_IRQ_PERIPHERAL_IRQ_ENABLE];
          s_next.global_irq_enable = wd[`NOA_BIT_IRQ_GIE];
        end
        default: ;
      endcase
      // while off the buffer tracks every step byte write immediately
      if (!s_reg.module_on && (i_wb_adr == `NOA_OFS_STEP_LOW ||
          i_wb_adr == `NOA_OFS_STEP_HIGH || i_wb_adr == `NOA_OFS_STEP_UPPER)) begin
        s_next.step_buf = s_next.phase_step;
      end
    end

    // hardware set beats a same-cycle software clear
    if (ovf || (pol_evt && s_reg.overflow_irq_enable)) begin
      s_next.overflow_irq_flag = 1'b1;
    end
    s_next.output_level = s_next.raw ^ s_next.output_invert;
    s_next.irq_req = s_next.overflow_irq_flag & s_next.module_on &
      s_next.overflow_irq_enable & s_next.peripheral_irq_enable &
      s_next.global_irq_enable;
    s_next.keep_osc = s_next.module_on &
      (s_next.clock_source_code == NOA_SRC_FAST_OSC);

    // read data captured with the ack; unmapped reads return zero
    if (req) begin
      s_next.ack = 1'b1;
      case (i_wb_adr)
        `NOA_OFS_CONTROL: s_next.rdata = {s_reg.module_on, 1'b0, s_reg.output_level,
          s_reg.output_invert, 3'h0, s_reg.pulse_mode_select};
        `NOA_OFS_CLOCK: s_next.rdata = {s_reg.pulse_width_code, 3'h0,
          s_reg.clock_source_code};
        `NOA_OFS_ACC_LOW: s_next.rdata = s_reg.phase_accumulator[7:0];
        `NOA_OFS_ACC_HIGH: s_next.rdata = s_reg.phase_accumulator[15:8];
        `NOA_OFS_ACC_UPPER: s_next.rdata = {4'h0, s_reg.phase_accumulator[19:16]};
        `NOA_OFS_STEP_LOW: s_next.rdata = s_reg.phase_step[7:0];
        `NOA_OFS_STEP_HIGH: s_next.rdata = s_reg.phase_step[15:8];
        `NOA_OFS_STEP_UPPER: s_next.rdata = {4'h0, s_reg.phase_step[19:16]};
        `NOA_OFS_IRQ: s_next.rdata = {4'h0, s_reg.global_irq_enable,
          s_reg.peripheral_irq_enable, s_reg.overflow_irq_enable, s_reg.overflow_irq_flag};
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_reg <= '0;
      s_reg.phase_step <= `NOA_STEP_RESET;
      s_reg.step_buf <= `NOA_STEP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_wb_dat = {24'h000000, s_reg.rdata};
  assign o_wb_ack = s_reg.ack;
  assign o_osc_out = s_reg.output_level;
  assign o_irq_req = s_reg.irq_req;
  assign o_keep_fast_osc = s_reg.keep_osc;

endmodule

// *** logic/noa_pkg.sv ***
// types shared by the oscillator design files
package noa_pkg;

  typedef enum logic [1:0] {
    NOA_SRC_FAST_OSC,
    NOA_SRC_SYS_CLK,
    NOA_SRC_LOGIC_CELL3,
    NOA_SRC_RESERVED
  } noa_clk_src_t;

  typedef struct packed {
    logic module_on;
    logic output_invert;
    logic pulse_mode_select;
    logic [2:0] pulse_width_code;
    noa_clk_src_t clock_source_code;
    logic [19:0] phase_accumulator;
    logic [19:0] phase_step;
    logic [19:0] step_buf;
    logic [1:0] xfer_cnt;
    logic ovf_pend;
    logic [7:0] pulse_left;
    logic raw;
    logic output_level;
    logic overflow_irq_flag;
    logic overflow_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic irq_req;
    logic keep_osc;
    logic ack;
    logic [7:0] rdata;
  } noa_state_t;

endpackage

// *** verification/noa_far_model.sv ***
// far-side model: input clock sources and consumer of the oscillator output
`timescale 1ns/10ps
module noa_far_model (
  input wire logic i_clk,
  input wire logic i_lc3_req,
  input wire logic i_osc_out,
  output logic o_fast_osc = 1'b0,
  output logic o_lc3 = 1'b0,
  output int o_edges = 0
);
  logic [2:0] div_reg = 3'h0;
  logic [2:0] hold_reg = 3'h0;
  logic last_reg = 1'b0;
  // fast oscillator runs at an eighth of the bus clock, logic cell input once per lc3 request, both well under the edge-sampling limit
  always @(posedge i_clk) begin
    div_reg <= div_reg + 3'h1;
    o_fast_osc <= div_reg[2];
    if (i_lc3_req) begin
      hold_reg <= 3'h7;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
    o_lc3 <= hold_reg[2];
    last_reg <= i_osc_out;
    if (i_osc_out !== last_reg) o_edges <= o_edges + 1;
  end
endmodule

// *** verification/noa_osc_accum_sva.sv ***
// port checks of the oscillator
`timescale 1ns/10ps
`include "noa_defs.svh"
module noa_osc_accum_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`NOA_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_fast_internal_osc,
  input wire logic i_logic_cell3_output,
  input wire logic o_osc_out,
  input wire logic o_irq_req,
  input wire logic o_keep_fast_osc
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_take ##0 (!i_wb_we && i_wb_adr == a);
  endsequence
  AST_ACK_PULSE: assert property (s_take |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not a single pulse one cycle after request");
  AST_ACK_CAUSE: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  AST_DAT_HI: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_ACC_NIB: assert property (s_rd(8'h10) |=> o_wb_dat[7:4] == 4'h0)
    else $error("accumulator upper nibble not zero");
  AST_STEP_NIB: assert property (s_rd(8'h1c) |=> o_wb_dat[7:4] == 4'h0)
    else $error("step upper nibble not zero");
  AST_CTRL_GAP: assert property (s_rd(8'h00) |=> !o_wb_dat[6] && o_wb_dat[3:1] == 3'h0)
    else $error("control unused bits not zero");
  AST_CLK_GAP: assert property (s_rd(8'h04) |=> o_wb_dat[4:2] == 3'h0)
    else $error("clock register unused bits not zero");
  AST_LEVEL: assert property (s_rd(8'h00) ##1 $stable(o_osc_out) |-> o_wb_dat[5] == o_osc_out)
    else $error("level bit differs from output");
  AST_RESET: assert property (disable iff (1'b0) !i_nrst |=>
    !o_wb_ack && !o_osc_out && !o_irq_req && !o_keep_fast_osc)
    else $error("outputs not cleared by reset");
endmodule
bind noa_osc_accum noa_osc_accum_sva u_noa_osc_accum_sva (.*);

// *** verification/noa_osc_accum_tb.sv ***
// self-checking bench for the phase accumulator oscillator
`timescale 1ns/10ps
module noa_osc_accum_tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic lreq = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd, q;
  logic ack, out, irq, keep, fosc, lc3;
  int n_fail = 0;
  int check_count = 0;
  int ticks = 0;
  int edges, hi, tog;
  always #12.5 i_clk = ~i_clk;
  noa_osc_accum u_noa_osc_accum (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wd),
    .o_wb_dat(rd), .o_wb_ack(ack), .i_fast_internal_osc(fosc), .i_logic_cell3_output(lc3),
    .o_osc_out(out), .o_irq_req(irq), .o_keep_fast_osc(keep));
  noa_far_model u_noa_far_model (.i_clk(i_clk), .i_lc3_req(lreq), .i_osc_out(out),
    .o_fast_osc(fosc), .o_lc3(lc3), .o_edges(edges));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // one classic cycle; the answer is awaited, only the global timeout ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge i_clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("register %h", a), {24'h0, e}, q);
  endtask
  // settles first so the window sees whole output periods only
  task automatic meas(input int n);
    int e0;
    repeat (16) @(posedge i_clk);
    e0 = edges;
    hi = 0;
    repeat (n) begin
      @(posedge i_clk);
      hi += int'(out === 1'b1);
    end
    tog = edges - e0;
  endtask
  task automatic pulse_lc3(input int n);
    repeat (n) begin
      lreq <= 1'b1;
      @(posedge i_clk);
      lreq <= 1'b0;
      repeat (11) @(posedge i_clk);
    end
  endtask
  task automatic t_reset();
    for (int a = 0; a <= 36; a += 4) begin
      rdchk(a[7:0], (a == 20) ? 8'h01 : 8'h00);
    end
    bus(1'b1, 8'h10, 8'hff);
    rdchk(8'h10, 8'h0f);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h1c, 8'hf8);
    rdchk(8'h1c, 8'h08);
    bus(1'b1, 8'h14, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_toggle();
    bus(1'b1, 8'h04, 8'h01);
    meas(10);
    chk("idle toggles", 32'h0, tog);
    bus(1'b1, 8'h00, 8'h80);
    meas(40);
    chk("toggles", 32'h14, tog);
    chk("duty", 32'h14, hi);
    bus(1'b1, 8'h1c, 8'h02);
    bus(1'b1, 8'h18, 8'h00);
    bus(1'b1, 8'h14, 8'h00);
    for (int c = 2; c >= 0; c--) begin
      bus(1'b1, 8'h04, {c[2:0], 5'h01}); // widths stay under the 8-tick period
      bus(1'b1, 8'h00, 8'h81);
      meas(80);
      chk("pulse highs", 32'ha << c, hi);
    end
    bus(1'b1, 8'h00, 8'h91);
    meas(80);
    chk("inverted highs", 32'h46, hi);
    $display("test modes done");
  endtask
  task automatic t_src();
    bus(1'b1, 8'h00, 8'h00);
    bus(1'b1, 8'h1c, 8'h00);
    bus(1'b1, 8'h14, 8'h00);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h04, 8'h02);
    bus(1'b1, 8'h00, 8'h80);
    bus(1'b1, 8'h1c, 8'h08);
    bus(1'b1, 8'h14, 8'h00);
    tog = edges;
    pulse_lc3(2);
    chk("early load", tog, edges);
    pulse_lc3(2);
    chk("late load", tog + 1, edges);
    bus(1'b1, 8'h04, 8'h03);
    tog = edges;
    pulse_lc3(2);
    chk("reserved source", tog, edges);
    bus(1'b1, 8'h04, 8'h00);
    chk("keep osc", 32'h1, keep);
    meas(64);
    chk("fast source toggles", 32'h4, tog);
    $display("test sources done");
  endtask
  task automatic t_irq();
    rdchk(8'h20, 8'h01);
    bus(1'b1, 8'h20, 8'h0b);
    chk("gated request", 32'h0, irq);
    bus(1'b1, 8'h20, 8'h0f);
    chk("request", 32'h1, irq);
    bus(1'b1, 8'h00, 8'h00);
    chk("request when off", 32'h0, irq);
    rdchk(8'h20, 8'h0f);
    bus(1'b1, 8'h20, 8'h02);
    rdchk(8'h20, 8'h02);
    bus(1'b1, 8'h00, 8'h10);
    rdchk(8'h20, 8'h03);
    chk("inactive output", 32'h1, out);
    rdchk(8'h00, 8'h30);
    bus(1'b1, 8'h00, 8'h20);
    rdchk(8'h00, 8'h00);
    $display("test interrupts done");
  endtask
  always @(posedge i_clk) begin
    ticks++;
    if (ticks == 4000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_toggle();
    t_src();
    t_irq();
    finish_test();
  end
endmodule
